// >>> common/srs_pkg.sv
package srs_pkg;

  // timing figures, and the cycle counts derived from them
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PLL_WAIT_NS = 1000000;
  localparam int unsigned CDR_WAIT_NS = 2000000;
  // least times round up to whole cycles
  localparam int unsigned PLL_WAIT_CYC = (PLL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CDR_WAIT_CYC = (CDR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // register map (byte offsets, low address bits only)
  localparam int REG_AW = 4;
  localparam logic [REG_AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [REG_AW-1:0] OFS_CLKINFO = 4'h8;

  // control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_LEGACY_BIT = 0;
  localparam int CTRL_DIV_LSB = 1;
  localparam int CTRL_EXT_BIT = 3;
  localparam int CTRL_BAUD_LSB = 4;
  localparam int CTRL_QUAD_BIT = 6;
  localparam int CTRL_RESTART_BIT = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h02;

  // divide ratio and baud codes
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] BAUD_3G125 = 2'h0;
  localparam logic [1:0] BAUD_2G5 = 2'h1;

  // expected core clock in kHz
  localparam logic [31:0] KHZ_X1_3G125 = 32'h0001312d;
  localparam logic [31:0] KHZ_X1_2G5 = 32'h0000f424;
  localparam logic [31:0] KHZ_X1_1G25 = 32'h00007a12;
  localparam logic [31:0] KHZ_X4_3G125 = 32'h0002625a;
  localparam logic [31:0] KHZ_X4_2G5 = 32'h0001e848;
  localparam logic [31:0] KHZ_X4_1G25 = 32'h0000f424;

  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PLL_LOCK = 3;
  localparam int ST_CDR_LOCK = 4;
  localparam int ST_DRV_EN = 5;
  localparam int ST_PLL_CLR = 6;
  localparam int ST_TXL_CLR = 7;
  localparam int ST_RXL_CLR = 8;
  localparam int ST_RXA_CLR = 9;
  localparam int ST_CORE_HOLD = 10;

  localparam logic [1:0] HTRANS_NONSEQ_BIT1 = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    SEQ_HOLD = 3'h0,
    SEQ_PLL_WAIT = 3'h1,
    SEQ_LOCK_WAIT = 3'h3,
    SEQ_CDR_WAIT = 3'h2,
    SEQ_CDR_DELAY = 3'h6,
    SEQ_RUN = 3'h7
  } srs_seq_t;

endpackage

// >>> rtl/srs_sync2.sv
`timescale 1ns/1ns
// two-stage level synchroniser; stage one feeds stage two only
module srs_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // srs_sync2

// >>> rtl/srs_reset_sequencer.sv
`timescale 1ns/1ns
// Contract
// - resets assert anytime, release aligned to clock
// - core holds active during master reset
// - all transceiver clears active during master reset
// - legacy type waits 1 ms, releases pll clear
// - await pll lock, release tx/analog clears
// - await cdr lock, 2 ms, release rx logic
// - finally release both core holds
// - silent state forces tx logic clear
// - external phy disabled while silent
// - core clock by flop divider 2/4; divide-by-one holds it high
// - single lane core clock half transceiver clock
// - four lane clocks 156.25/125/62.5 MHz
// - core clock drives tx and pll reference
module srs_reset_sequencer
  import srs_pkg::*;
#(
  parameter logic [CNT_W-1:0] PLL_WAIT_CYCLES = CNT_W'(PLL_WAIT_CYC),
  parameter logic [CNT_W-1:0] CDR_WAIT_CYCLES = CNT_W'(CDR_WAIT_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic serdes_pll_lock,
  input wire logic rx_cdr_freq_lock,
  input wire logic line_driver_enable,
  output logic serdes_pll_async_clear,
  output logic serdes_tx_logic_clear,
  output logic serdes_rx_logic_clear,
  output logic serdes_rx_analog_clear,
  output logic rx_core_hold,
  output logic tx_core_hold,
  output logic ext_phy_tx_disable,
  output logic tx_core_clk,
  output logic tx_core_tick
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ---------------- bus slave ----------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic restart_q;
  logic restart_d;
  logic wr_pend_q;
  logic [REG_AW-1:0] wr_addr_q;
  logic [31:0] rdata_w;
  logic [31:0] status_w;
  logic [31:0] clkinfo_w;
  logic [REG_AW-1:0] addr_lo;
  logic accept;
  logic wr_ctrl;

  // hsize is not checked: only whole-word transfers are used on this slave
  assign addr_lo = haddr[REG_AW-1:0];
  assign accept = hsel && hready && ((htrans & HTRANS_NONSEQ_BIT1) != 2'h0);
  assign wr_ctrl = wr_pend_q && (wr_addr_q == OFS_CTRL);
  // forwarding the pending write keeps back-to-back write/read coherent
  assign ctrl_d = wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl_q;
  assign restart_d = wr_ctrl && hwdata[CTRL_RESTART_BIT];

  assign rdata_w = (addr_lo == OFS_CTRL) ? {{(32 - CTRL_W){1'b0}}, ctrl_d} :
                   (addr_lo == OFS_STATUS) ? status_w :
                   (addr_lo == OFS_CLKINFO) ? clkinfo_w : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata <= 32'h00000000;
      ctrl_q <= CTRL_RST;
      restart_q <= 1'b0;
    end else begin
      wr_pend_q <= accept && hwrite;
      wr_addr_q <= accept ? addr_lo : wr_addr_q;
      hrdata <= (accept && !hwrite) ? rdata_w : hrdata;
      ctrl_q <= ctrl_d;
      restart_q <= restart_d;
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ---------------- configuration fields ----------------
  logic legacy;
  logic ext_mode;
  logic quad_lane;
  logic [1:0] div_sel;
  logic [1:0] baud_sel;

  assign legacy = ctrl_q[CTRL_LEGACY_BIT];
  assign ext_mode = ctrl_q[CTRL_EXT_BIT];
  assign quad_lane = ctrl_q[CTRL_QUAD_BIT];
  assign div_sel = ctrl_q[CTRL_DIV_LSB +: 2];
  assign baud_sel = ctrl_q[CTRL_BAUD_LSB +: 2];

  // core clock expected for the chosen lane count and baud rate
  assign clkinfo_w = quad_lane ?
                     ((baud_sel == BAUD_3G125) ? KHZ_X4_3G125 :
                      (baud_sel == BAUD_2G5) ? KHZ_X4_2G5 : KHZ_X4_1G25) :
                     ((baud_sel == BAUD_3G125) ? KHZ_X1_3G125 :
                      (baud_sel == BAUD_2G5) ? KHZ_X1_2G5 : KHZ_X1_1G25);

  // ---------------- lock synchronisers ----------------
  logic [1:0] lock_raw;
  logic [1:0] lock_s;
  logic pll_lock_s;
  logic cdr_lock_s;

  assign lock_raw = {rx_cdr_freq_lock, serdes_pll_lock};

  srs_sync2 #(.WIDTH(2)) u_lock_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(lock_raw),
    .q(lock_s)
  );

  assign pll_lock_s = lock_s[0];
  assign cdr_lock_s = lock_s[1];

  // ---------------- sequencer ----------------
  srs_seq_t seq_q;
  srs_seq_t seq_d;
  logic [CNT_W-1:0] wait_cnt_q;
  logic [CNT_W-1:0] wait_cnt_d;
  logic pll_wait_done;
  logic cdr_wait_done;
  logic early_phase;

  // the wait counter runs on hclk, which never stops
  assign pll_wait_done = (wait_cnt_q >= PLL_WAIT_CYCLES - 1'b1);
  assign cdr_wait_done = (wait_cnt_q >= CDR_WAIT_CYCLES - 1'b1);
  assign wait_cnt_d = (seq_d != seq_q) ? '0 :
                      (wait_cnt_q == {CNT_W{1'b1}}) ? wait_cnt_q : wait_cnt_q + 1'b1;

  always_comb begin
    seq_d = seq_q;
    unique case (seq_q)
      SEQ_HOLD: seq_d = legacy ? SEQ_PLL_WAIT : SEQ_LOCK_WAIT;
      SEQ_PLL_WAIT: if (pll_wait_done) seq_d = SEQ_LOCK_WAIT;
      SEQ_LOCK_WAIT: if (pll_lock_s) seq_d = SEQ_CDR_WAIT;
      SEQ_CDR_WAIT: if (cdr_lock_s) seq_d = SEQ_CDR_DELAY;
      SEQ_CDR_DELAY: if (cdr_wait_done) seq_d = SEQ_RUN;
      SEQ_RUN: seq_d = SEQ_RUN;
      default: seq_d = SEQ_HOLD;
    endcase
    // software restart re-runs the whole sequence
    if (restart_q) begin
      seq_d = SEQ_HOLD;
    end
  end

  assign early_phase = (seq_d == SEQ_HOLD) || (seq_d == SEQ_PLL_WAIT) ||
                       (seq_d == SEQ_LOCK_WAIT);

  // every clear is set by the async reset and released only on an hclk edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q <= SEQ_HOLD;
      wait_cnt_q <= '0;
      rx_core_hold <= 1'b1;
      tx_core_hold <= 1'b1;
      serdes_pll_async_clear <= 1'b1;
      serdes_tx_logic_clear <= 1'b1;
      serdes_rx_logic_clear <= 1'b1;
      serdes_rx_analog_clear <= 1'b1;
      ext_phy_tx_disable <= 1'b0;
    end else begin
      seq_q <= seq_d;
      wait_cnt_q <= wait_cnt_d;
      serdes_pll_async_clear <= (seq_d == SEQ_HOLD) || (seq_d == SEQ_PLL_WAIT);
      serdes_tx_logic_clear <= early_phase || !line_driver_enable;
      serdes_rx_analog_clear <= early_phase;
      serdes_rx_logic_clear <= (seq_d != SEQ_RUN);
      // holds drop one edge after the rx logic clear, so they are last
      rx_core_hold <= (seq_q != SEQ_RUN) || (seq_d != SEQ_RUN);
      tx_core_hold <= (seq_q != SEQ_RUN) || (seq_d != SEQ_RUN);
      ext_phy_tx_disable <= ext_mode && !line_driver_enable;
    end
  end

  // ---------------- status ----------------
  assign status_w[ST_STATE_LSB +: 3] = seq_q;
  assign status_w[ST_PLL_LOCK] = pll_lock_s;
  assign status_w[ST_CDR_LOCK] = cdr_lock_s;
  assign status_w[ST_DRV_EN] = line_driver_enable;
  assign status_w[ST_PLL_CLR] = serdes_pll_async_clear;
  assign status_w[ST_TXL_CLR] = serdes_tx_logic_clear;
  assign status_w[ST_RXL_CLR] = serdes_rx_logic_clear;
  assign status_w[ST_RXA_CLR] = serdes_rx_analog_clear;
  assign status_w[ST_CORE_HOLD] = tx_core_hold;
  assign status_w[31:ST_CORE_HOLD+1] = '0;

  // ---------------- core clock divider ----------------
  // a flop cannot reproduce hclk itself: divide-by-one holds the clock high
  // and the tick marks every hclk edge instead
  logic [1:0] div_cnt_q;
  logic clk_d;
  logic tick_d;

  assign clk_d = (div_sel == DIV_BY1) ? 1'b1 :
                 (div_sel == DIV_BY2) ? ~tx_core_clk :
                 (div_cnt_q[0] ? ~tx_core_clk : tx_core_clk);
  assign tick_d = (div_sel == DIV_BY1) ? 1'b1 : (clk_d && !tx_core_clk);

  // one divided clock feeds both tx logic and the transceiver pll reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 2'h0;
      tx_core_clk <= 1'b0;
      tx_core_tick <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
      tx_core_clk <= clk_d;
      tx_core_tick <= tick_d;
    end
  end

  // ---------------- checks ----------------
  logic [CNT_W-1:0] stay_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stay_q <= '0;
    end else if (seq_d != seq_q) begin
      stay_q <= '0;
    end else if (stay_q != {CNT_W{1'b1}}) begin
      stay_q <= stay_q + 1'b1;
    end
  end

  a_hold_until_run: assert property ((seq_q != SEQ_RUN) |-> ##1 (rx_core_hold && tx_core_hold))
    else $error("core hold released before run");
  a_clears_in_hold: assert property ((seq_q == SEQ_HOLD) |-> (serdes_pll_async_clear &&
      serdes_tx_logic_clear && serdes_rx_logic_clear && serdes_rx_analog_clear))
    else $error("transceiver clear missing in hold");
  a_pll_wait_time: assert property (($fell(serdes_pll_async_clear) && legacy) |->
      ($past(seq_q) == SEQ_PLL_WAIT) && ($past(stay_q) >= PLL_WAIT_CYCLES - 1'b1))
    else $error("pll clear released before wait");
  a_tx_needs_lock: assert property ($fell(serdes_rx_analog_clear) |->
      $past(pll_lock_s) && !serdes_pll_async_clear)
    else $error("analog clear released without pll lock");
  a_cdr_wait_time: assert property ($fell(serdes_rx_logic_clear) |->
      ($past(seq_q) == SEQ_CDR_DELAY) && ($past(stay_q) >= CDR_WAIT_CYCLES - 1'b1))
    else $error("rx logic clear released too early");
  // the tx logic clear is left out: a silent line may legally hold it at release
  a_hold_last: assert property ($fell(tx_core_hold) |-> !serdes_rx_logic_clear &&
      !serdes_rx_analog_clear && !$past(serdes_rx_logic_clear))
    else $error("core hold released before clears");
  a_silent_clear: assert property (!line_driver_enable |=> serdes_tx_logic_clear)
    else $error("tx logic not cleared while silent");
  a_ext_disable: assert property (##1 (ext_phy_tx_disable ==
      ($past(ext_mode) && !$past(line_driver_enable))))
    else $error("external disable mismatch");
  a_div_two: assert property ((div_sel == DIV_BY2) [*2] |-> (tx_core_clk != $past(tx_core_clk)))
    else $error("divide by two clock not toggling");
  a_div_four: assert property ((div_sel == DIV_BY4) [*4] |->
      (tx_core_clk != $past(tx_core_clk, 2)) &&
      ((tx_core_clk == $past(tx_core_clk)) ^ ($past(tx_core_clk) == $past(tx_core_clk, 2))))
    else $error("divide by four period wrong");

  c_reach_run: cover property (seq_q == SEQ_CDR_DELAY ##1 seq_q == SEQ_RUN);
  c_legacy_release: cover property (legacy && $fell(serdes_pll_async_clear));
  c_silent_run: cover property (seq_q == SEQ_RUN && !line_driver_enable);
  c_restart: cover property (seq_q == SEQ_RUN ##1 restart_q);

endmodule // srs_reset_sequencer

// >>> testbench/srs_xcvr_model.sv
`timescale 1ns/1ns
// transceiver stand-in: each lock comes a set number of cycles after its clear drops
module srs_xcvr_model (
  input wire logic hclk,
  input wire logic serdes_pll_async_clear,
  input wire logic serdes_rx_analog_clear,
  input wire logic [7:0] pll_dly,
  input wire logic [7:0] cdr_dly,
  output logic serdes_pll_lock,
  output logic rx_cdr_freq_lock
);
  logic [7:0] pll_q;
  logic [7:0] cdr_q;
  // a clear drops the lock at once, with no regard to the clock
  always_ff @(posedge hclk or posedge serdes_pll_async_clear) begin
    if (serdes_pll_async_clear)
      pll_q <= 8'h00;
    else if (pll_q < pll_dly)
      pll_q <= pll_q + 8'h01;
  end
  // frequency lock needs the pll locked first
  always_ff @(posedge hclk or posedge serdes_rx_analog_clear) begin
    if (serdes_rx_analog_clear)
      cdr_q <= 8'h00;
    else if (!serdes_pll_lock)
      cdr_q <= 8'h00;
    else if (cdr_q < cdr_dly)
      cdr_q <= cdr_q + 8'h01;
  end
  assign serdes_pll_lock = !serdes_pll_async_clear && pll_q >= pll_dly;
  assign rx_cdr_freq_lock = serdes_pll_lock && !serdes_rx_analog_clear && cdr_q >= cdr_dly;
endmodule // srs_xcvr_model

// >>> testbench/tb_serdes_reset_sequencer.sv
`timescale 1ns/1ns
module tb_serdes_reset_sequencer;
  import srs_pkg::*;
  localparam int PLLW = 8;
  localparam int CDRW = 12;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, wd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pll_lock, cdr_lock, drv_en, pll_clr, txl_clr, rxl_clr, rxa_clr;
  logic rx_hold, tx_hold, ext_dis, core_clk, core_tick;
  logic [7:0] pll_dly, cdr_dly;
  int fail_count, num_checks, seed, tk, hi;
  int ev[8];
  assign hready = hreadyout;
  srs_reset_sequencer #(.PLL_WAIT_CYCLES(CNT_W'(PLLW)), .CDR_WAIT_CYCLES(CNT_W'(CDRW))) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .serdes_pll_lock(pll_lock), .rx_cdr_freq_lock(cdr_lock), .line_driver_enable(drv_en),
    .serdes_pll_async_clear(pll_clr), .serdes_tx_logic_clear(txl_clr),
    .serdes_rx_logic_clear(rxl_clr), .serdes_rx_analog_clear(rxa_clr),
    .rx_core_hold(rx_hold), .tx_core_hold(tx_hold), .ext_phy_tx_disable(ext_dis),
    .tx_core_clk(core_clk), .tx_core_tick(core_tick));
  srs_xcvr_model xcvr_u (
    .hclk(hclk), .serdes_pll_async_clear(pll_clr), .serdes_rx_analog_clear(rxa_clr),
    .pll_dly(pll_dly), .cdr_dly(cdr_dly), .serdes_pll_lock(pll_lock),
    .rx_cdr_freq_lock(cdr_lock));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (num_checks > 0 && fail_count == 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one single transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  // first cycle at which each lock rises or each clear and hold drops
  task automatic watch_seq();
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
      ev[i] = -1;
    for (int t = 0; t < 400 && ev[0] < 0; t++) begin
      @(negedge hclk);
      v = {pll_lock, cdr_lock, ~pll_clr, ~txl_clr, ~rxl_clr, ~rxa_clr, ~tx_hold, ~rx_hold};
      for (int i = 0; i < 8; i++)
        if (ev[i] < 0 && v[i] === 1'b1)
          ev[i] = t;
    end
  endtask
  task automatic seq_checks(input bit legacy);
    chk("pll_clear_fall", 1, legacy ? ev[5] >= PLLW - 1 : ev[5] <= 3);
    chk("tx_clear_after_lock", 1, ev[4] >= ev[7] + 2);
    chk("analog_with_tx", ev[4], ev[2]);
    chk("rx_clear_after_cdr", 1, ev[3] >= ev[6] + CDRW);
    chk("hold_after_rx", ev[3] + 1, ev[1]);
    chk("holds_together", ev[1], ev[0]);
  endtask
  function automatic logic [31:0] khz(input int q, input int b);
    logic [31:0] base;
    base = (b == 0) ? 32'h7a12 * 5 / 2 : (b == 1) ? 32'h7a12 * 2 : 32'h7a12;
    return (q != 0) ? base * 2 : base;
  endfunction
  initial begin
    seed = 25;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    drv_en = 1'b1;
    pll_dly = 8'h05;
    cdr_dly = 8'h07;
    repeat (8) @(posedge hclk);
    chk("clears_in_reset", 4'hf, {pll_clr, txl_clr, rxl_clr, rxa_clr});
    chk("holds_in_reset", 2'h3, {rx_hold, tx_hold});
    hresetn <= 1'b1;
    watch_seq();
    seq_checks(1'b0);
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl_reset", 32'h2, rd);
    $display("test plain sequence done");
    pll_dly <= 8'($random(seed) & 32'h1f) + 8'h01;
    cdr_dly <= 8'($random(seed) & 32'h1f) + 8'h01;
    ahb(1'b1, 32'h0, 32'h103);
    settle(1);
    chk("clears_on_restart", 4'hf, {pll_clr, txl_clr, rxl_clr, rxa_clr});
    chk("holds_on_restart", 2'h3, {rx_hold, tx_hold});
    watch_seq();
    seq_checks(1'b1);
    $display("test legacy restart done");
    ahb(1'b1, 32'h0, 32'ha);
    drv_en <= 1'b0;
    settle(2);
    chk("tx_clear_silent", 1, txl_clr);
    chk("ext_off_silent", 1, ext_dis);
    ahb(1'b1, 32'h0, 32'h2);
    settle(2);
    chk("ext_mode_off", 0, ext_dis);
    @(posedge hclk);
    drv_en <= 1'b1;
    settle(2);
    chk("tx_clear_resume", 0, txl_clr);
    $display("test silent done");
    for (int c = 0; c < 4; c++) begin
      ahb(1'b1, 32'h0, 32'(c << 1));
      settle(4);
      tk = 0;
      hi = 0;
      repeat (16) begin
        @(negedge hclk);
        tk += int'(core_tick);
        hi += int'(core_clk);
      end
      chk("tick_count", (c == 0) ? 16 : (c == 1) ? 8 : 4, tk);
      chk("clk_high", (c == 0) ? 16 : 8, hi);
    end
    $display("test divider done");
    for (int q = 0; q < 2; q++)
      for (int b = 0; b < 3; b++) begin
        ahb(1'b1, 32'h0, 32'((q << 6) | (b << 4) | 2));
        ahb(1'b0, 32'h8, 32'h0);
        chk("core_khz", khz(q, b), rd);
      end
    $display("test clock info done");
    repeat (4) begin
      wd = $random(seed) & 32'h7f;
      ahb(1'b1, 32'h0, wd);
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl_rw", wd, rd);
    end
    ahb(1'b0, (32'($random(seed)) & 32'hfffffff0) | 32'hc, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, 32'h4, 32'hffffffff);
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl_kept", wd, rd);
    ahb(1'b0, 32'h4, 32'h0);
    chk("state_run", 32'(SEQ_RUN), 32'(rd[2:0]));
    chk("resp_okay", 32'(HRESP_OKAY), 32'(hresp));
    chk("ready_high", 32'h1, 32'(hreadyout));
    $display("test registers done");
    give_verdict();
  end
  // the whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    give_verdict();
  end
endmodule // tb_serdes_reset_sequencer
